// *** core/kmn_navigator.sv ***
// keypad menu navigator: function-code walk, data edit and apply logic
//
// Overview of operation
// - menu steps in units of four-character codes
// - groups: one monitor, seven program, errors unreachable
// - program indicator lit unless monitor item shown
// - monitor values are read-only, edits refused
// - main-profile edits apply immediately except one
// - cancel on code moves to next group
// - cancel on data discards edit, shows code
// - store toggles code to data, commits data
// - up/down change data; both enter digit edit
// - cancel held over one second shows first monitor item
// - held cancel on code steps one group on its press edge, then waits for the jump
`timescale 1ns/10ps
module kmn_navigator #(
    parameter int HOLD_CYCLES = kmn_pkg::HOLD_CYCLES
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RST,
    input  wire logic                        CANCEL_KEY,
    input  wire logic                        STORE_KEY,
    input  wire logic                        UP_KEY,
    input  wire logic                        DOWN_KEY,
    input  wire logic [kmn_pkg::DATA_W-1:0]  MONITOR_VALUE,
    output logic      [kmn_pkg::GROUP_W-1:0] DISP_GROUP,
    output logic      [kmn_pkg::ITEM_W-1:0]  DISP_INDEX,
    output logic      [7:0]                  DISP_LETTER,
    output logic                             SHOW_DATA,
    output logic                             DIGIT_MODE,
    output logic      [1:0]                  DIGIT_CURSOR,
    output logic      [kmn_pkg::DATA_W-1:0]  DISP_VALUE,
    output logic                             PROGRAM_INDICATOR,
    output logic                             APPLY_STB,
    output logic      [kmn_pkg::ADDR_W-1:0]  APPLY_ADDR,
    output logic      [kmn_pkg::DATA_W-1:0]  APPLY_VALUE
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    kmn_pkg::kmn_keys_type              keys;
    kmn_pkg::kmn_keys_type              prev;
    kmn_pkg::kmn_ui_type                cur;
    kmn_pkg::kmn_ui_type                next_cur;
    kmn_pkg::kmn_out_type               out_q;
    kmn_pkg::kmn_out_type               next_out_q;
    logic [31:0]                        hold_cnt;
    logic [31:0]                        next_hold_cnt;
    logic                               hold_done;
    logic                               next_hold_done;
    logic [kmn_pkg::DATA_W-1:0]         store_mem [kmn_pkg::NUM_ITEMS];
    logic                               mem_we;
    logic [kmn_pkg::ADDR_W-1:0]         addr;
    logic                               cancel_rise;
    logic                               store_rise;
    logic                               up_only;
    logic                               down_only;
    logic                               both_keys;
    logic                               is_monitor;
    logic                               immediate;
    logic                               hold_jump;
    logic [kmn_pkg::DATA_W-1:0]         step;
    logic                               show_data;
    logic                               next_show_data;
    logic                               digit_mode;
    logic                               next_digit_mode;

    assign keys = '{cancel: CANCEL_KEY, store: STORE_KEY, up: UP_KEY, down: DOWN_KEY};

    // key edges; a lone up or down is one whose partner is released
    assign cancel_rise = keys.cancel & ~prev.cancel;
    assign store_rise  = keys.store & ~prev.store;
    assign up_only     = keys.up & ~prev.up & ~keys.down;
    assign down_only   = keys.down & ~prev.down & ~keys.up;
    assign both_keys   = keys.up & keys.down & ((keys.up & ~prev.up) | (keys.down & ~prev.down));

    assign addr       = {cur.group, cur.index};
    assign is_monitor = (cur.group == kmn_pkg::MONITOR_GROUP);
    assign immediate  = (cur.group == kmn_pkg::MAIN_PROFILE_GROUP) &&
                        (cur.index != kmn_pkg::DEFERRED_MAIN_ITEM);
    assign hold_jump  = keys.cancel && !hold_done &&
                        (hold_cnt == 32'(HOLD_CYCLES - 1));
    assign step       = kmn_pkg::DATA_W'(1) << (kmn_pkg::DIGIT_W * cur.cursor);

    // ----------------------------------------
    // next-state computation
    // ----------------------------------------
    always_comb begin
        next_cur       = cur;
        next_out_q     = out_q;
        next_hold_cnt  = hold_cnt;
        next_hold_done = hold_done;
        mem_we         = 1'b0;
        next_out_q.apply_stb  = 1'b0;
        next_out_q.apply_addr = addr;

        // cancel hold timer; the jump fires once per hold
        if (keys.cancel) begin
            if (!hold_done) begin
                next_hold_cnt = hold_cnt + 32'h0000_0001;
            end
            if (hold_jump) begin
                next_hold_done = 1'b1;
            end
        end else begin
            next_hold_cnt  = 32'h0000_0000;
            next_hold_done = 1'b0;
        end

        unique case (cur.state)
            kmn_pkg::ST_CODE: begin
                if (cancel_rise) begin
                    // wrap past the last group; the error group is never entered
                    next_cur.group = (cur.group == kmn_pkg::LAST_GROUP) ?
                                     kmn_pkg::MONITOR_GROUP : cur.group + 3'h1;
                    next_cur.index = kmn_pkg::FIRST_ITEM;
                end else if (store_rise) begin
                    next_cur.state = kmn_pkg::ST_DATA;
                    next_cur.edit  = is_monitor ? MONITOR_VALUE : store_mem[addr];
                    next_cur.orig  = is_monitor ? MONITOR_VALUE : store_mem[addr];
                end else if (up_only) begin
                    next_cur.index = cur.index + 3'h1;
                end else if (down_only) begin
                    next_cur.index = cur.index - 3'h1;
                end
            end
            kmn_pkg::ST_DATA: begin
                if (is_monitor) begin
                    next_cur.edit = MONITOR_VALUE;
                end
                if (cancel_rise) begin
                    next_cur.state = kmn_pkg::ST_CODE;
                    next_cur.edit  = cur.orig;
                end else if (store_rise) begin
                    next_cur.state = kmn_pkg::ST_CODE;
                    if (!is_monitor) begin
                        mem_we                 = 1'b1;
                        next_out_q.apply_stb   = 1'b1;
                        next_out_q.apply_value = cur.edit;
                    end
                end else if (!is_monitor && both_keys) begin
                    next_cur.state  = kmn_pkg::ST_DIGIT;
                    next_cur.cursor = 2'h0;
                end else if (!is_monitor && up_only) begin
                    next_cur.edit = cur.edit + kmn_pkg::DATA_W'(1);
                end else if (!is_monitor && down_only) begin
                    next_cur.edit = cur.edit - kmn_pkg::DATA_W'(1);
                end
            end
            kmn_pkg::ST_DIGIT: begin
                // cancel walks left and leaves past the top digit, store walks right
                if (cancel_rise) begin
                    if (cur.cursor == kmn_pkg::TOP_CURSOR) begin
                        next_cur.state = kmn_pkg::ST_CODE;
                        next_cur.edit  = cur.orig;
                    end else begin
                        next_cur.cursor = cur.cursor + 2'h1;
                    end
                end else if (store_rise) begin
                    if (cur.cursor == 2'h0) begin
                        next_cur.state         = kmn_pkg::ST_CODE;
                        mem_we                 = 1'b1;
                        next_out_q.apply_stb   = 1'b1;
                        next_out_q.apply_value = cur.edit;
                    end else begin
                        next_cur.cursor = cur.cursor - 2'h1;
                    end
                end else if (up_only) begin
                    next_cur.edit = cur.edit + step;
                end else if (down_only) begin
                    next_cur.edit = cur.edit - step;
                end
            end
            // the unused state code falls back to the code display
            default: begin
                next_cur.state = kmn_pkg::ST_CODE;
            end
        endcase

        // live items follow every change, including the restore on cancel
        if (immediate && (cur.state != kmn_pkg::ST_CODE) && (next_cur.edit != cur.edit)) begin
            next_out_q.apply_stb   = 1'b1;
            next_out_q.apply_value = next_cur.edit;
        end

        // the long hold overrides whatever the cancel edge did
        if (hold_jump) begin
            next_cur.state = kmn_pkg::ST_DATA;
            next_cur.group = kmn_pkg::MONITOR_GROUP;
            next_cur.index = kmn_pkg::FIRST_ITEM;
            next_cur.edit  = MONITOR_VALUE;
            next_cur.orig  = MONITOR_VALUE;
        end

        next_out_q.prog_ind   = (next_cur.group != kmn_pkg::MONITOR_GROUP);
        next_out_q.letter     = kmn_pkg::GROUP_LETTER[next_cur.group];
        next_out_q.disp_value = (next_cur.state == kmn_pkg::ST_CODE) ?
                                kmn_pkg::RESET_VALUE : next_cur.edit;
        // mode flags are registered so that no top output is a decode
        next_show_data  = (next_cur.state != kmn_pkg::ST_CODE);
        next_digit_mode = (next_cur.state == kmn_pkg::ST_DIGIT);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prev      <= '0;
            hold_cnt  <= 32'h0000_0000;
            hold_done <= 1'b0;
            show_data <= 1'b0;
            digit_mode <= 1'b0;
            cur       <= '{state: kmn_pkg::ST_CODE, group: kmn_pkg::MONITOR_GROUP,
                           index: kmn_pkg::FIRST_ITEM, cursor: 2'h0,
                           edit: kmn_pkg::RESET_VALUE, orig: kmn_pkg::RESET_VALUE};
            out_q     <= '{apply_stb: 1'b0, apply_addr: '0,
                           apply_value: kmn_pkg::RESET_VALUE, prog_ind: 1'b0,
                           letter: kmn_pkg::GROUP_LETTER[kmn_pkg::MONITOR_GROUP],
                           disp_value: kmn_pkg::RESET_VALUE};
        end else begin
            prev      <= keys;
            hold_cnt  <= next_hold_cnt;
            hold_done <= next_hold_done;
            show_data <= next_show_data;
            digit_mode <= next_digit_mode;
            cur       <= next_cur;
            out_q     <= next_out_q;
        end
    end

    // stored parameter values, written only by a commit
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < kmn_pkg::NUM_ITEMS; i++) begin
                store_mem[i] <= kmn_pkg::RESET_VALUE;
            end
        end else if (mem_we) begin
            store_mem[addr] <= cur.edit;
        end
    end

    assign DISP_GROUP        = cur.group;
    assign DISP_INDEX        = cur.index;
    assign DISP_LETTER       = out_q.letter;
    assign SHOW_DATA         = show_data;
    assign DIGIT_MODE        = digit_mode;
    assign DIGIT_CURSOR      = cur.cursor;
    assign DISP_VALUE        = out_q.disp_value;
    assign PROGRAM_INDICATOR = out_q.prog_ind;
    assign APPLY_STB         = out_q.apply_stb;
    assign APPLY_ADDR        = out_q.apply_addr;
    assign APPLY_VALUE       = out_q.apply_value;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    property p_indicator;
        PROGRAM_INDICATOR == (DISP_GROUP != kmn_pkg::MONITOR_GROUP);
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator wrong");

    property p_monitor_ro;
        APPLY_STB |->
        (APPLY_ADDR[kmn_pkg::ADDR_W-1 -: kmn_pkg::GROUP_W] != kmn_pkg::MONITOR_GROUP);
    endproperty
    a_monitor_ro: assert property (p_monitor_ro) else $error("monitor applied");

    property p_immediate;
        (cur.state == kmn_pkg::ST_DATA) && immediate && up_only && !cancel_rise &&
        !store_rise && !hold_jump |=> APPLY_STB && (APPLY_VALUE == $past(cur.edit) + 16'h0001);
    endproperty
    a_immediate: assert property (p_immediate) else $error("no live apply");

    property p_deferred;
        (cur.state == kmn_pkg::ST_DATA) && !immediate && !store_rise |=> !APPLY_STB;
    endproperty
    a_deferred: assert property (p_deferred) else $error("early apply");

    property p_next_group;
        (cur.state == kmn_pkg::ST_CODE) && cancel_rise && !hold_jump |=>
        (DISP_GROUP == $past(cur.group) + 3'h1) && (DISP_INDEX == kmn_pkg::FIRST_ITEM);
    endproperty
    a_next_group: assert property (p_next_group) else $error("group step wrong");

    property p_discard;
        (cur.state == kmn_pkg::ST_DATA) && cancel_rise && !hold_jump && !immediate |=>
        !SHOW_DATA && !APPLY_STB;
    endproperty
    a_discard: assert property (p_discard) else $error("cancel not discarded");

    property p_store_open;
        (cur.state == kmn_pkg::ST_CODE) && store_rise && !cancel_rise && !hold_jump |=>
        SHOW_DATA && !DIGIT_MODE && (DISP_INDEX == $past(cur.index));
    endproperty
    a_store_open: assert property (p_store_open) else $error("store did not open");

    property p_code_step;
        (cur.state == kmn_pkg::ST_CODE) && up_only && !cancel_rise && !store_rise &&
        !hold_jump |=> DISP_INDEX == $past(cur.index) + 3'h1;
    endproperty
    a_code_step: assert property (p_code_step) else $error("code step wrong");

    property p_digit;
        (cur.state == kmn_pkg::ST_DATA) && !is_monitor && both_keys && !cancel_rise &&
        !store_rise && !hold_jump |=> DIGIT_MODE && (DIGIT_CURSOR == 2'h0);
    endproperty
    a_digit: assert property (p_digit) else $error("digit mode missed");

    property p_hold_jump;
        hold_jump |=> SHOW_DATA && !DIGIT_MODE && (DISP_GROUP == kmn_pkg::MONITOR_GROUP) &&
        (DISP_INDEX == kmn_pkg::FIRST_ITEM) ##1 (DISP_GROUP == kmn_pkg::MONITOR_GROUP);
    endproperty
    a_hold_jump: assert property (p_hold_jump) else $error("hold jump wrong");
endmodule

// *** core/kmn_pkg.sv ***
// constants and types shared by the keypad menu navigator
package kmn_pkg;
    // ----------------------------------------
    // menu geometry
    // ----------------------------------------
    localparam int GROUP_W    = 3;
    localparam int ITEM_W     = 3;
    localparam int ADDR_W     = GROUP_W + ITEM_W;
    localparam int NUM_ITEMS  = 64;
    localparam int DATA_W     = 16;
    localparam int CODE_CHARS = 4;
    localparam int DIGIT_W    = 4;

    // group order walked by the cancel key; group 0 is the monitor group
    localparam logic [GROUP_W-1:0] MONITOR_GROUP      = 3'h0;
    localparam logic [GROUP_W-1:0] MAIN_PROFILE_GROUP = 3'h1;
    localparam logic [GROUP_W-1:0] LAST_GROUP         = 3'h7;
    localparam logic [ITEM_W-1:0]  FIRST_ITEM         = 3'h0;
    // the one main-profile item that waits for the store key
    localparam logic [ITEM_W-1:0]  DEFERRED_MAIN_ITEM = 3'h4;

    // leading character of each reachable group, then the error group
    localparam logic [7:0] GROUP_LETTER [8] = '{8'h44, 8'h46, 8'h41, 8'h42,
                                               8'h43, 8'h48, 8'h50, 8'h55};
    localparam logic [7:0] ERROR_LETTER = 8'h45;

    localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
    localparam logic [1:0]        TOP_CURSOR  = 2'h3;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLOCK_HZ     = 20_000_000;
    localparam int HOLD_TIME_MS = 1000;
    localparam int HOLD_CYCLES  = HOLD_TIME_MS * (CLOCK_HZ / 1000);

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {ST_CODE, ST_DATA, ST_DIGIT} kmn_state_type;

    typedef struct packed {
        logic cancel;
        logic store;
        logic up;
        logic down;
    } kmn_keys_type;

    typedef struct packed {
        kmn_state_type       state;
        logic [GROUP_W-1:0]  group;
        logic [ITEM_W-1:0]   index;
        logic [1:0]          cursor;
        logic [DATA_W-1:0]   edit;
        logic [DATA_W-1:0]   orig;
    } kmn_ui_type;

    typedef struct packed {
        logic                apply_stb;
        logic [ADDR_W-1:0]   apply_addr;
        logic [DATA_W-1:0]   apply_value;
        logic                prog_ind;
        logic [7:0]          letter;
        logic [DATA_W-1:0]   disp_value;
    } kmn_out_type;
endpackage

// *** test/kmn_operator.sv ***
// operator model: presses and holds front-panel keys on the falling clock edge
`timescale 1ns/10ps
module kmn_operator (
    input  wire logic             CLOCK,
    output kmn_pkg::kmn_keys_type KEYS
);
    // ----------------------------------------
    // key actions
    // ----------------------------------------
    // all keys up at power-on, so the first press is a clean edge
    initial KEYS = 4'h0;

    // hold a key pattern for n falling edges and leave it down
    task automatic hold(input kmn_pkg::kmn_keys_type k, input int n);
        @(negedge CLOCK);
        KEYS = k;
        repeat (n - 1) @(negedge CLOCK);
    endtask

    // press for n cycles, release, then pause so the next press is a fresh edge
    task automatic press(input kmn_pkg::kmn_keys_type k, input int n);
        hold(k, n);
        @(negedge CLOCK);
        KEYS = 4'h0;
        repeat (2) @(negedge CLOCK);
    endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for the keypad menu navigator
`timescale 1ns/10ps
module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int HOLD = 50; // short hold count keeps the run brief
    localparam kmn_pkg::kmn_keys_type K_CANCEL = 4'h8;
    localparam kmn_pkg::kmn_keys_type K_STORE  = 4'h4;
    localparam kmn_pkg::kmn_keys_type K_UP     = 4'h2;
    localparam kmn_pkg::kmn_keys_type K_DOWN   = 4'h1;
    localparam kmn_pkg::kmn_keys_type K_BOTH   = 4'h3;
    logic                  clock, rst, show_data, digit_mode, prog_ind, apply_stb;
    kmn_pkg::kmn_keys_type keys;
    logic [15:0]           monitor_value, disp_value, apply_value, last_val, v, orig;
    logic [2:0]            disp_group, disp_index, exp_group, exp_index;
    logic [7:0]            disp_letter;
    logic [1:0]            digit_cursor;
    logic [5:0]            apply_addr, last_addr, a;
    logic [15:0]           stored [64];
    logic [31:0]           rnd;
    int                    errors, n_checks, n_stb, s0, i;

    kmn_navigator #(.HOLD_CYCLES(HOLD)) i_kmn_navigator (
        .CLOCK(clock), .RST(rst), .CANCEL_KEY(keys.cancel), .STORE_KEY(keys.store),
        .UP_KEY(keys.up), .DOWN_KEY(keys.down), .MONITOR_VALUE(monitor_value),
        .DISP_GROUP(disp_group), .DISP_INDEX(disp_index), .DISP_LETTER(disp_letter),
        .SHOW_DATA(show_data), .DIGIT_MODE(digit_mode), .DIGIT_CURSOR(digit_cursor),
        .DISP_VALUE(disp_value), .PROGRAM_INDICATOR(prog_ind), .APPLY_STB(apply_stb),
        .APPLY_ADDR(apply_addr), .APPLY_VALUE(apply_value)
    );
    kmn_operator i_kmn_operator (.CLOCK(clock), .KEYS(keys));

    // ----------------------------------------
    // clock and strobe capture
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // strobes last one cycle, so they are counted here rather than polled
    always @(posedge clock) begin
        if (apply_stb === 1'b1) begin
            n_stb     <= n_stb + 1;
            last_addr <= apply_addr;
            last_val  <= apply_value;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // walk the code display to group g, item idx; down wraps for high items
    task automatic go_to(input logic [2:0] g, input logic [2:0] idx);
        int n;
        n = ((int'(g) - int'(exp_group) + 7) % 8) + 1;
        repeat (n) begin
            i_kmn_operator.press(K_CANCEL, 1);
            exp_group = exp_group + 3'h1;
            check("group", 32'(disp_group), 32'(exp_group));
        end
        check("index", 32'(disp_index), 32'h0000_0000);
        exp_index = 3'h0;
        while (exp_index != idx) begin
            i_kmn_operator.press(idx < 3'h4 ? K_UP : K_DOWN, 1);
            exp_index = idx < 3'h4 ? exp_index + 3'h1 : exp_index - 3'h1;
            check("index", 32'(disp_index), 32'(exp_index));
        end
        check("letter", 32'(disp_letter), 32'(kmn_pkg::GROUP_LETTER[g]));
        check("indicator", 32'(prog_ind), 32'(g != 3'h0));
        a = {g, idx};
    endtask

    // deferred item: steps show but stay out of effect until stored
    task automatic edit_commit(input logic [2:0] g, input logic [2:0] idx, input int k);
        go_to(g, idx);
        s0 = n_stb;
        i_kmn_operator.press(K_STORE, 1 + k);
        check("show_data", 32'(show_data), 32'h0000_0001);
        check("value", 32'(disp_value), 32'(stored[a]));
        v = stored[a];
        repeat (k) begin
            i_kmn_operator.press(K_UP, k);
            v = v + 16'h0001;
        end
        i_kmn_operator.press(K_DOWN, 1);
        v = v - 16'h0001;
        check("value", 32'(disp_value), 32'(v));
        check("strobes", 32'(n_stb), 32'(s0));
        i_kmn_operator.press(K_STORE, 1);
        check("show_data", 32'(show_data), 32'h0000_0000);
        check("strobes", 32'(n_stb), 32'(s0 + 1));
        check("apply_addr", 32'(last_addr), 32'(a));
        check("apply_value", 32'(last_val), 32'(v));
        stored[a] = v;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        monitor_value = 16'h0000;
        errors = 0;
        n_checks = 0;
        n_stb = 0;
        rnd = 32'h0000_0033;
        exp_group = 3'h0;
        exp_index = 3'h0;
        foreach (stored[j]) stored[j] = 16'h0000;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        check("letter", 32'(disp_letter), 32'h0000_0044);
        check("show_data", 32'(show_data), 32'h0000_0000);
        check("indicator", 32'(prog_ind), 32'h0000_0000);
        // monitor item: live value shown, up and both-keys edits refused, store returns without apply
        rnd = xorshift(rnd);
        monitor_value = rnd[15:0];
        i_kmn_operator.press(K_STORE, 1);
        check("value", 32'(disp_value), 32'(monitor_value));
        i_kmn_operator.press(K_UP, 1);
        i_kmn_operator.press(K_BOTH, 1);
        check("digit_mode", 32'(digit_mode), 32'h0000_0000);
        rnd = xorshift(rnd);
        monitor_value = rnd[15:0];
        repeat (2) @(negedge clock);
        check("value", 32'(disp_value), 32'(monitor_value));
        i_kmn_operator.press(K_STORE, 1);
        check("show_data", 32'(show_data), 32'h0000_0000);
        check("strobes", 32'(n_stb), 32'h0000_0000);
        // live main-profile item: one up step applies at once, cancel restores
        rnd = xorshift(rnd);
        go_to(kmn_pkg::MAIN_PROFILE_GROUP, {1'b0, rnd[1:0]});
        s0 = n_stb;
        i_kmn_operator.press(K_STORE, 1);
        orig = stored[a];
        i_kmn_operator.press(K_UP, 1);
        check("strobes", 32'(n_stb), 32'(s0 + 1));
        check("apply_value", 32'(last_val), 32'(orig + 16'h0001));
        check("apply_addr", 32'(last_addr), 32'(a));
        i_kmn_operator.press(K_CANCEL, 1);
        check("show_data", 32'(show_data), 32'h0000_0000);
        check("apply_value", 32'(last_val), 32'(orig));
        i_kmn_operator.press(K_STORE, 1);
        check("value", 32'(disp_value), 32'(orig));
        i_kmn_operator.press(K_CANCEL, 1);
        // deferred main item, then one random item in every other program group
        edit_commit(kmn_pkg::MAIN_PROFILE_GROUP, kmn_pkg::DEFERRED_MAIN_ITEM, 2);
        for (int g = 2; g < 8; g++) begin
            rnd = xorshift(rnd);
            edit_commit(3'(g), rnd[2:0], int'(rnd[4:3]) + 1);
        end
        // digit-by-digit edit: nibble steps, cursor moves, commit at bottom digit
        rnd = xorshift(rnd);
        go_to(3'h3, rnd[2:0]);
        i_kmn_operator.press(K_STORE, 1);
        v = stored[a];
        i_kmn_operator.press(K_BOTH, 1);
        check("digit_mode", 32'(digit_mode), 32'h0000_0001);
        check("cursor", 32'(digit_cursor), 32'h0000_0000);
        check("value", 32'(disp_value), 32'(v));
        i_kmn_operator.press(K_UP, 1);
        i_kmn_operator.press(K_CANCEL, 1);
        check("cursor", 32'(digit_cursor), 32'h0000_0001);
        i_kmn_operator.press(K_UP, 1);
        v = v + 16'h0011;
        check("value", 32'(disp_value), 32'(v));
        i_kmn_operator.press(K_DOWN, 1);
        v = v - 16'h0010;
        check("value", 32'(disp_value), 32'(v));
        i_kmn_operator.press(K_STORE, 1);
        i_kmn_operator.press(K_STORE, 1);
        check("digit_mode", 32'(digit_mode), 32'h0000_0000);
        check("apply_value", 32'(last_val), 32'(v));
        stored[a] = v;
        // leaving digit edit past the top digit drops the edit without applying it
        s0 = n_stb;
        i_kmn_operator.press(K_STORE, 1);
        i_kmn_operator.press(K_BOTH, 1);
        i_kmn_operator.press(K_UP, 1);
        repeat (4) i_kmn_operator.press(K_CANCEL, 1);
        check("show_data", 32'(show_data), 32'h0000_0000);
        check("digit_mode", 32'(digit_mode), 32'h0000_0000);
        check("strobes", 32'(n_stb), 32'(s0));
        i_kmn_operator.press(K_STORE, 1);
        check("value", 32'(disp_value), 32'(v));
        i_kmn_operator.press(K_CANCEL, 1);
        // long cancel hold: one group step first, then the jump to the first monitor item
        i_kmn_operator.hold(K_CANCEL, 10);
        check("group", 32'(disp_group), 32'h0000_0004);
        check("show_data", 32'(show_data), 32'h0000_0000);
        for (i = 0; i < HOLD + 20 && show_data !== 1'b1; i++) @(negedge clock);
        if (i >= HOLD + 20) begin
            errors++; // a hold that never jumps counts as a mismatch
        end
        check("hold_time", 32'(i >= HOLD - 10 && i <= HOLD - 7), 32'h0000_0001);
        check("group", 32'(disp_group), 32'h0000_0000);
        check("index", 32'(disp_index), 32'h0000_0000);
        check("value", 32'(disp_value), 32'(monitor_value));
        i_kmn_operator.press(4'h0, 1);
        print_verdict();
    end
endmodule
